/* rtl/dcs_map.svh */
// Register offsets, field positions and reset values of the clock-stop control block
`ifndef DCS_MAP_SVH
`define DCS_MAP_SVH
`define DCS_OFF_DOWN 8'h86
`define DCS_OFF_UP 8'h87
`define DCS_OFF_INTR 8'h88
`define DCS_OFF_RSVD 8'h89
`define DCS_OFF_GFX 8'h8A
`define DCS_REG_RESET 8'h00
`define DCS_BIT_DOWN 0
`define DCS_BIT_UP0 0
`define DCS_BIT_UP1 1
`define DCS_BIT_UP2 2
`define DCS_BIT_UP3 3
`define DCS_BIT_INTR_RP 1
`define DCS_BIT_INTR_SLOW 0
`define DCS_BIT_GFX_TYP 7
`define DCS_BIT_GFX_PRI 6
`define DCS_BIT_GFX_RD 5
`define DCS_UP_MASK 8'h0F
`define DCS_INTR_MASK 8'h03
`define DCS_GFX_MASK 8'hE0
`define DCS_DOWN_MASK 8'h01
`define DCS_ROOT_PORT_MHZ 250
`endif

/* rtl/dcs_pkg.sv */
// Types shared by the clock-stop control block
package dcs_pkg;
    // Number of root ports
    localparam int DCS_PORTS = 4;
    // Gated clock index order on the enable outputs
    typedef enum logic [3:0] {
        DCS_CK_DOWN = 4'h0,
        DCS_CK_UP0 = 4'h1,
        DCS_CK_UP1 = 4'h2,
        DCS_CK_UP2 = 4'h3,
        DCS_CK_UP3 = 4'h4,
        DCS_CK_INTR_RP = 4'h5,
        DCS_CK_INTR_SLOW = 4'h6,
        DCS_CK_GFX_TYP = 4'h7,
        DCS_CK_GFX_PRI = 4'h8,
        DCS_CK_GFX_RD = 4'h9
    } dcs_clk_idx_t;
    localparam int DCS_NCLK = 10;
    // Registered state of the block
    typedef struct packed {
        logic [7:0] down_ctl;
        logic [7:0] up_ctl;
        logic [7:0] intr_ctl;
        logic [7:0] gfx_ctl;
        logic [7:0] rd_data;
        logic [9:0] clk_run;
    } dcs_state_t;
endpackage : dcs_pkg

/* rtl/dcs_gate.sv */
// Dynamic clock-stop enable logic with its configuration registers
`timescale 1ns/1ps
`include "dcs_map.svh"
module dcs_gate (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic [7:0] cfg_addr_in,
    input wire logic [7:0] cfg_wdata_in,
    input wire logic cfg_wr_in,
    input wire logic cfg_rd_in,
    output logic [7:0] cfg_rdata_out,
    input wire logic global_stop_enable_in,
    input wire logic traffic_unit_stop_enable_in,
    input wire logic intr_unit_stop_enable_in,
    input wire logic gfx_mem_unit_stop_enable_in,
    input wire logic down_busy_in,
    input wire logic [dcs_pkg::DCS_PORTS-1:0] up_busy_in,
    input wire logic intr_event_in,
    input wire logic slow_pending_in,
    input wire logic gfx_typ_req_in,
    input wire logic gfx_pri_req_in,
    input wire logic mem_rd_return_in,
    output logic [dcs_pkg::DCS_NCLK-1:0] clk_run_out
);
    import dcs_pkg::*;

    // Present and next state
    dcs_state_t st;
    dcs_state_t next_st;
    // Per-clock stop permission and idle indication
    logic [DCS_NCLK-1:0] stop_ok;
    logic [DCS_NCLK-1:0] idle;
    // Level-1 enable per clock, unit enable only; the global bit is and-ed in the stop term
    logic [DCS_NCLK-1:0] lvl1;
    // Local enable bit per clock
    logic [DCS_NCLK-1:0] local_en;

    // Collect local bits, unit enables and idle terms per clock
    always_comb begin
        lvl1 = {DCS_NCLK{1'b0}};
        lvl1[DCS_CK_DOWN] = traffic_unit_stop_enable_in;
        lvl1[DCS_CK_UP0] = traffic_unit_stop_enable_in;
        lvl1[DCS_CK_UP1] = traffic_unit_stop_enable_in;
        lvl1[DCS_CK_UP2] = traffic_unit_stop_enable_in;
        lvl1[DCS_CK_UP3] = traffic_unit_stop_enable_in;
        // root-port clock also serves interrupt unit
        lvl1[DCS_CK_INTR_RP] = intr_unit_stop_enable_in;
        lvl1[DCS_CK_INTR_SLOW] = intr_unit_stop_enable_in;
        lvl1[DCS_CK_GFX_TYP] = gfx_mem_unit_stop_enable_in;
        lvl1[DCS_CK_GFX_PRI] = gfx_mem_unit_stop_enable_in;
        lvl1[DCS_CK_GFX_RD] = gfx_mem_unit_stop_enable_in;
        local_en[DCS_CK_DOWN] = st.down_ctl[`DCS_BIT_DOWN];
        // one upstream bit per root port
        local_en[DCS_CK_UP0] = st.up_ctl[`DCS_BIT_UP0];
        local_en[DCS_CK_UP1] = st.up_ctl[`DCS_BIT_UP1];
        local_en[DCS_CK_UP2] = st.up_ctl[`DCS_BIT_UP2];
        local_en[DCS_CK_UP3] = st.up_ctl[`DCS_BIT_UP3];
        local_en[DCS_CK_INTR_RP] = st.intr_ctl[`DCS_BIT_INTR_RP];
        local_en[DCS_CK_INTR_SLOW] = st.intr_ctl[`DCS_BIT_INTR_SLOW];
        local_en[DCS_CK_GFX_TYP] = st.gfx_ctl[`DCS_BIT_GFX_TYP];
        local_en[DCS_CK_GFX_PRI] = st.gfx_ctl[`DCS_BIT_GFX_PRI];
        local_en[DCS_CK_GFX_RD] = st.gfx_ctl[`DCS_BIT_GFX_RD];
        // Idle conditions of each path
        idle[DCS_CK_DOWN] = ~down_busy_in;
        idle[DCS_CK_UP0] = ~up_busy_in[0];
        idle[DCS_CK_UP1] = ~up_busy_in[1];
        idle[DCS_CK_UP2] = ~up_busy_in[2];
        idle[DCS_CK_UP3] = ~up_busy_in[3];
        idle[DCS_CK_INTR_RP] = ~intr_event_in;
        idle[DCS_CK_INTR_SLOW] = ~slow_pending_in;
        idle[DCS_CK_GFX_TYP] = ~gfx_typ_req_in;
        idle[DCS_CK_GFX_PRI] = ~gfx_pri_req_in;
        idle[DCS_CK_GFX_RD] = ~mem_rd_return_in;
    end

    // One stop term per gated clock
    genvar gi;
    generate
        for (gi = 0; gi < DCS_NCLK; gi++) begin : g_stop
            assign stop_ok[gi] = global_stop_enable_in & lvl1[gi] & local_en[gi] & idle[gi];
        end
    endgenerate

    // Register writes, read data and clock run enables
    always_comb begin
        next_st = st;
        // run flag follows busy one cycle after it arrives
        next_st.clk_run = ~stop_ok;
        if (cfg_wr_in) begin
            unique case (cfg_addr_in)
                `DCS_OFF_DOWN: next_st.down_ctl = cfg_wdata_in & `DCS_DOWN_MASK;
                `DCS_OFF_UP: next_st.up_ctl = cfg_wdata_in & `DCS_UP_MASK;
                `DCS_OFF_INTR: next_st.intr_ctl = cfg_wdata_in & `DCS_INTR_MASK;
                `DCS_OFF_GFX: next_st.gfx_ctl = cfg_wdata_in & `DCS_GFX_MASK;
                // Reserved and unmapped bytes ignore writes
                default: begin
                end
            endcase
        end
        // Read data; reserved and unmapped read zero
        next_st.rd_data = `DCS_REG_RESET;
        if (cfg_rd_in) begin
            unique case (cfg_addr_in)
                `DCS_OFF_DOWN: next_st.rd_data = st.down_ctl;
                `DCS_OFF_UP: next_st.rd_data = st.up_ctl;
                `DCS_OFF_INTR: next_st.rd_data = st.intr_ctl;
                `DCS_OFF_GFX: next_st.rd_data = st.gfx_ctl;
                default: next_st.rd_data = `DCS_REG_RESET;
            endcase
        end
    end

    // State register; clocks run freely out of reset
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            st.down_ctl <= `DCS_REG_RESET;
            st.up_ctl <= `DCS_REG_RESET;
            st.intr_ctl <= `DCS_REG_RESET;
            st.gfx_ctl <= `DCS_REG_RESET;
            st.rd_data <= `DCS_REG_RESET;
            st.clk_run <= {DCS_NCLK{1'b1}};
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from flops; the clock cell latches this on the low phase
    assign cfg_rdata_out = st.rd_data;
    assign clk_run_out = st.clk_run;

    // Restart lags the first busy cycle by one clock; the gate cell must cover that gap
    // global clear forces every clock running next cycle
    a_global_off_runs: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        !global_stop_enable_in |=> &clk_run_out)
        else $error("clock stopped with global off");
    // a stopped downstream clock needs all its enables
    a_stop_needs_all: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        !clk_run_out[DCS_CK_DOWN] |-> $past(global_stop_enable_in & traffic_unit_stop_enable_in
        & st.down_ctl[`DCS_BIT_DOWN])) else $error("downstream stopped without enables");
    // traffic unit clear frees its five clocks
    a_traffic_off_runs: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        !traffic_unit_stop_enable_in |=> &clk_run_out[DCS_CK_UP3:DCS_CK_DOWN])
        else $error("traffic clock stopped with unit off");
    // interrupt unit clear frees both its clocks
    a_intr_off_runs: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        !intr_unit_stop_enable_in |=> clk_run_out[DCS_CK_INTR_RP] && clk_run_out[DCS_CK_INTR_SLOW])
        else $error("intr clock stopped with unit off");
    // memory interface clear frees its three clocks
    a_gfx_off_runs: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        !gfx_mem_unit_stop_enable_in |=> &clk_run_out[DCS_CK_GFX_RD:DCS_CK_GFX_TYP])
        else $error("memory clock stopped with unit off");
    // downstream stops when idle and enabled
    a_down_stops: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        stop_ok[DCS_CK_DOWN] |=> !clk_run_out[DCS_CK_DOWN])
        else $error("downstream kept running");
    // downstream cycle keeps its clock running
    a_down_busy_runs: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        down_busy_in |=> clk_run_out[DCS_CK_DOWN])
        else $error("downstream stopped while busy");
    // port 3 busy restarts its clock
    a_up3_busy_runs: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        up_busy_in[3] |=> clk_run_out[DCS_CK_UP3])
        else $error("port 3 stopped while busy");
    // port 0 clock tied to its own bit
    a_up0_own_bit: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        !clk_run_out[DCS_CK_UP0] |-> $past(st.up_ctl[`DCS_BIT_UP0] & !up_busy_in[0]))
        else $error("port 0 gated by wrong bit");
    // port 1 clock tied to its own bit
    a_up1_own_bit: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        !clk_run_out[DCS_CK_UP1] |-> $past(st.up_ctl[`DCS_BIT_UP1] & !up_busy_in[1]))
        else $error("port 1 gated by wrong bit");
    // port 2 stops when idle and enabled
    a_up2_stops: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        stop_ok[DCS_CK_UP2] |=> !clk_run_out[DCS_CK_UP2])
        else $error("port 2 kept running");
    // interrupt event keeps root-port clock running
    a_intr_rp_runs: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        intr_event_in |=> clk_run_out[DCS_CK_INTR_RP])
        else $error("intr clock stopped on event");
    // pending work keeps slow clock running
    a_slow_runs: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        slow_pending_in |=> clk_run_out[DCS_CK_INTR_SLOW])
        else $error("slow clock stopped");
    // slow clock stops when nothing is pending and all its enables are set
    a_slow_stops: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        stop_ok[DCS_CK_INTR_SLOW] |=> !clk_run_out[DCS_CK_INTR_SLOW])
        else $error("slow clock kept running");
    // typical request keeps memory clock running
    a_typ_runs: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        gfx_typ_req_in |=> clk_run_out[DCS_CK_GFX_TYP])
        else $error("typical clock stopped");
    // priority request keeps memory clock running
    a_pri_runs: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        gfx_pri_req_in |=> clk_run_out[DCS_CK_GFX_PRI])
        else $error("priority clock stopped");
    // returning data keeps memory clock running
    a_rd_runs: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        mem_rd_return_in |=> clk_run_out[DCS_CK_GFX_RD])
        else $error("read clock stopped");
    // write then read returns masked value
    a_reg_readback: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        cfg_wr_in && cfg_addr_in == `DCS_OFF_UP ##1 cfg_rd_in && cfg_addr_in == `DCS_OFF_UP
        && !cfg_wr_in |=> cfg_rdata_out == ($past(cfg_wdata_in, 2) & `DCS_UP_MASK))
        else $error("upstream register readback wrong");

    // Main scenarios
    c_down_stop: cover property (@(posedge clk_in) disable iff (!reset_n_in)
        !clk_run_out[DCS_CK_DOWN] ##1 clk_run_out[DCS_CK_DOWN]);
    c_up3_stop: cover property (@(posedge clk_in) disable iff (!reset_n_in)
        !clk_run_out[DCS_CK_UP3]);
    c_intr_stop: cover property (@(posedge clk_in) disable iff (!reset_n_in)
        !clk_run_out[DCS_CK_INTR_RP] && !clk_run_out[DCS_CK_INTR_SLOW]);
    c_gfx_stop: cover property (@(posedge clk_in) disable iff (!reset_n_in)
        !clk_run_out[DCS_CK_GFX_RD]);
    // Read straight after a write
    c_readback: cover property (@(posedge clk_in) disable iff (!reset_n_in)
        cfg_wr_in ##1 cfg_rd_in ##1 cfg_rdata_out != `DCS_REG_RESET);
endmodule : dcs_gate

/* sim/dcs_gate_tb.sv */
// Self-checking testbench for the dynamic clock-stop gating block
`timescale 1ns/1ps
module dcs_gate_tb;
    import dcs_pkg::*;
    logic clk_in = 1'b0; // 10 MHz bench clock
    logic reset_n_in = 1'b0; // Async reset, active low
    logic [7:0] addr = 8'h00; // Register byte address
    logic [7:0] wdata = 8'h00; // Write data
    logic wr_s = 1'b0; // Write strobe
    logic rd_s = 1'b0; // Read strobe
    logic [7:0] rdata; // Read data from the block
    logic [9:0] run; // Clock run enables from the block
    logic [3:0] en = 4'h0; // Enables {global, traffic, intr, gfx}
    logic [9:0] act = 10'h000; // Activity {rd, pri, typ, slow, intr, up[3:0], down}
    logic [7:0] sh_dn, sh_up, sh_ic, sh_gc; // Expected register contents
    int bad_count = 0; // Mismatches seen
    int cmp_count = 0; // Comparisons made
    // Mixed busy patterns catch swapped or shared gating terms
    logic [9:0] pats [4] = '{10'h000, 10'h3FF, 10'h2A5, 10'h15A};
    dcs_gate dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .cfg_addr_in(addr),
        .cfg_wdata_in(wdata), .cfg_wr_in(wr_s), .cfg_rd_in(rd_s), .cfg_rdata_out(rdata),
        .global_stop_enable_in(en[3]), .traffic_unit_stop_enable_in(en[2]),
        .intr_unit_stop_enable_in(en[1]), .gfx_mem_unit_stop_enable_in(en[0]),
        .down_busy_in(act[0]), .up_busy_in(act[4:1]), .intr_event_in(act[5]),
        .slow_pending_in(act[6]), .gfx_typ_req_in(act[7]), .gfx_pri_req_in(act[8]),
        .mem_rd_return_in(act[9]), .clk_run_out(run));
    // Free-running clock, 100 ns period
    initial begin
        forever #50 clk_in = ~clk_in;
    end
    // Expected run enables: a clock stops only with every level set and its path idle
    function automatic logic [9:0] exp_run();
        logic [9:0] s;
        s[0] = en[3] & en[2] & sh_dn[0] & ~act[0];
        for (int n = 0; n < 4; n++) begin
            s[1+n] = en[3] & en[2] & sh_up[n] & ~act[1+n];
        end
        s[5] = en[3] & en[1] & sh_ic[1] & ~act[5];
        s[6] = en[3] & en[1] & sh_ic[0] & ~act[6];
        s[7] = en[3] & en[0] & sh_gc[7] & ~act[7];
        s[8] = en[3] & en[0] & sh_gc[6] & ~act[8];
        s[9] = en[3] & en[0] & sh_gc[5] & ~act[9];
        return ~s;
    endfunction : exp_run
    // Counted comparison with an immediate report
    task automatic check(input logic [9:0] got, input logic [9:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    // One-cycle write strobe, driven off the sampling edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_in);
        addr = a;
        wdata = d;
        wr_s = 1'b1;
        @(negedge clk_in);
        wr_s = 1'b0;
    endtask : wr
    // One-cycle read strobe; data is registered, so it shows one edge later
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk_in);
        addr = a;
        rd_s = 1'b1;
        @(negedge clk_in);
        rd_s = 1'b0;
        check({2'h0, rdata}, {2'h0, exp});
    endtask : rd_chk
    // Read every mapped and reserved place and one unmapped place against the shadows
    task automatic rd_all();
        rd_chk(8'h86, sh_dn);
        rd_chk(8'h87, sh_up);
        rd_chk(8'h88, sh_ic);
        rd_chk(8'h89, 8'h00);
        rd_chk(8'h8A, sh_gc);
        rd_chk(8'h90, 8'h00);
    endtask : rd_all
    // Write one value everywhere; reserved bits and the hole must drop it
    task automatic set_regs(input logic [7:0] d);
        wr(8'h86, d);
        wr(8'h87, d);
        wr(8'h88, d);
        wr(8'h89, d);
        wr(8'h8A, d);
        sh_dn = d & 8'h01;
        sh_up = d & 8'h0F;
        sh_ic = d & 8'h03;
        sh_gc = d & 8'hE0;
        rd_all();
    endtask : set_regs
    // Single place where the run ends
    task automatic report_and_stop();
        $display("Counts: comparisons=%0d mismatches=%0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : report_and_stop
    // Main sequence
    initial begin
        {sh_dn, sh_up, sh_ic, sh_gc} = 32'h0000_0000;
        repeat (16) @(negedge clk_in);
        reset_n_in = 1'b1;
        en = 4'hF;
        @(negedge clk_in);
        check(run, 10'h3FF);
        rd_all();
        @(negedge clk_in);
        check({2'h0, rdata}, 10'h000);
        $display("Test reset values done");
        // Enables, activity and local bits swept together
        for (int k = 0; k < 2; k++) begin
            set_regs(k == 0 ? 8'h5A : 8'hFF);
            for (int e = 0; e < 16; e++) begin
                for (int p = 0; p < 4; p++) begin
                    @(negedge clk_in);
                    en = e[3:0];
                    act = pats[p];
                    @(negedge clk_in);
                    check(run, exp_run());
                end
            end
        end
        $display("Test gating table done");
        // Stop everything, then wake each path alone and expect a restart next edge
        en = 4'hF;
        for (int b = 0; b < 10; b++) begin
            @(negedge clk_in);
            act = 10'h001 << b;
            @(negedge clk_in);
            check(run, ~(10'h3FF & ~act));
        end
        $display("Test restart done");
        // Read straight after a write must return the new masked value
        @(negedge clk_in);
        addr = 8'h87;
        wdata = 8'hA5;
        wr_s = 1'b1;
        @(negedge clk_in);
        wr_s = 1'b0;
        rd_s = 1'b1;
        @(negedge clk_in);
        rd_s = 1'b0;
        check({2'h0, rdata}, 10'h005);
        $display("Test write then read done");
        // Reset in mid-run clears the enables and frees all clocks
        @(negedge clk_in);
        act = 10'h000;
        reset_n_in = 1'b0;
        @(negedge clk_in);
        check(run, 10'h3FF);
        reset_n_in = 1'b1;
        {sh_dn, sh_up, sh_ic, sh_gc} = 32'h0000_0000;
        rd_all();
        @(negedge clk_in);
        check(run, 10'h3FF);
        $display("Test second reset done");
        report_and_stop();
    end
endmodule : dcs_gate_tb
